// ### hdl/cei_top.sv
// Purpose: Force and signalling-mode control of the comparator error notification
// Assumes: APB slave, one wait state per access; comparator error inputs are
//          single-cycle pulses from logic on CLK
//          Software keeps the reserved bits of every written word at zero
// Notes:   Source i of the input side sits in hw bit i, output side in hw bit 12+i
//          Event status clears on the edge that captures its read data, so an event
//          arriving later in the same access stays for the next read
//          Pulse mode keeps no record of enabled flags; the line pulse is all there is
//
// Contract
// RULE_01: Writing one to an input-side force bit sets that input-side error flag.
// RULE_02: Input-side force bits for sources 0..11 occupy printed bits 31 down to 20.
// RULE_03: Output-side force bits occupy printed bits 19..8 and set output-side flags.
// RULE_04: Writing zero to a force bit changes no flag and causes no event.
// RULE_05: Force bits clear themselves right after the write that set them.
// RULE_06: Force writes are ignored while register write protection is active.
// RULE_07: Reserved force and mode bits read as zero; software writes zeros.
// RULE_08: Two-bit mode field selects level, pulse, pulse-notify or single-pulse signalling.
// RULE_09: A notification flag clears on writing one; reads leave it unchanged.
// RULE_10: A flag drives the checker line only while its enable bit is one.
// RULE_11: Forced flags behave exactly like detected errors for gating and modes.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "cei_defs.svh"
`default_nettype none

module cei_top #(
  parameter int N_SRC = `CEI_N_SRC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Comparator error detections
  input  wire logic [11:0] INPUT_CMP_ERR,
  input  wire logic [11:0] OUTPUT_CMP_ERR,
  // Notification state and lines
  output logic [23:0]      ERROR_NOTIFICATION_FLAGS,
  output logic             CHECKER_INTERRUPT_LINE,
  output logic             IRQ
);

  if (N_SRC != `CEI_N_SRC) begin : g_chk_src
    $error("cei_top: N_SRC must be 12, the register layout is fixed");
  end

  // The flag word, its two halves and the event bits are laid out by hand below
  if (`CEI_N_FLAGS != 2 * N_SRC) begin : g_chk_flags
    $error("cei_top: the flag word must hold both comparator sides");
  end

  if (`CEI_IN_LSB != 0) begin : g_chk_in_side
    $error("cei_top: input source i must sit in flag bit i");
  end

  if (`CEI_OUT_LSB != `CEI_IN_LSB + N_SRC) begin : g_chk_sides
    $error("cei_top: the output side must follow the input side");
  end

  if (`CEI_N_FLAGS > 32 - 8) begin : g_chk_reserved
    $error("cei_top: the top eight bits of the force word are reserved");
  end

  if (`CEI_MODE_W != $bits(cei_pkg::cei_mode_e)) begin : g_chk_mode
    $error("cei_top: mode field width differs from the mode type");
  end

  if (`CEI_N_EVT > 32) begin : g_chk_evt_width
    $error("cei_top: event register wider than a bus word");
  end

  if (`CEI_EVT_ERROR >= `CEI_N_EVT) begin : g_chk_evt
    $error("cei_top: event bits exceed the event register");
  end

  // Bit helpers

  // Address match of a register
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Source field of a written word; reserved bits above are dropped
  function automatic cei_pkg::cei_flags_t src_field(input logic [31:0] word);
    src_field = word[`CEI_N_FLAGS-1:0];
  endfunction

  // APB access phase

  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic       access;
  logic       commit;
  logic       wr_commit;
  logic       mapped;

  logic [31:0] rd_word;

  // Register state
  cei_pkg::cei_flags_t notify_q;
  cei_pkg::cei_flags_t notify_d;
  cei_pkg::cei_flags_t enable_q;
  cei_pkg::cei_flags_t force_q;
  cei_pkg::cei_mode_e  mode_q;
  logic                protect_q;
  logic [`CEI_N_EVT-1:0] evt_mask_q;
  logic [`CEI_N_EVT-1:0] evt_status;
  logic                evt_irq;

  // Event terms
  cei_pkg::cei_flags_t hw_set;
  cei_pkg::cei_flags_t set_all;
  cei_pkg::cei_flags_t clr_w1;
  cei_pkg::cei_flags_t new_flags;
  logic                force_wr;
  logic                force_ok;
  logic                force_refused;
  logic                pending_en;
  logic                new_event_en;
  logic                line_q;
  logic [`CEI_N_EVT-1:0] evt_set;
  logic                status_rd_clr;

  // Register strobes
  logic                rd_snap;
  logic                wr_notify;
  logic                wr_enable;
  logic                wr_mode;
  logic                wr_ctrl;
  logic                wr_mask;

  // Access phase; answer on the second access cycle so PREADY is a flop
  assign access    = PSEL & PENABLE;
  assign commit    = access & pready_q;
  assign wr_commit = commit & PWRITE;

  // Read data is captured in the first access cycle, one edge before the commit
  assign rd_snap   = access & ~pready_q & ~PWRITE;

  // Write strobes, live only at the committing edge
  assign wr_notify = wr_commit & hit(PADDR, `CEI_OFS_NOTIFY);
  assign wr_enable = wr_commit & hit(PADDR, `CEI_OFS_ENABLE);
  assign wr_mode   = wr_commit & hit(PADDR, `CEI_OFS_MODE);
  assign wr_ctrl   = wr_commit & hit(PADDR, `CEI_OFS_CTRL);
  assign wr_mask   = wr_commit & hit(PADDR, `CEI_OFS_EVT_MASK);

  always_comb begin
    mapped = 1'b0;
    if (hit(PADDR, `CEI_OFS_NOTIFY)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_ENABLE)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_FORCE)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_MODE)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_CTRL)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_EVT_STATUS)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, `CEI_OFS_EVT_MASK)) begin
      mapped = 1'b1;
    end
  end

  // Read mux; every bit not listed reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(PADDR, `CEI_OFS_NOTIFY)) begin
      rd_word[`CEI_N_FLAGS-1:0] = notify_q;
    end else if (hit(PADDR, `CEI_OFS_ENABLE)) begin
      rd_word[`CEI_N_FLAGS-1:0] = enable_q;
    end else if (hit(PADDR, `CEI_OFS_FORCE)) begin
      // Force bits never hold between accesses, reserved bits zero
      rd_word = 32'h0000_0000;                                            // [RULE_07]
    end else if (hit(PADDR, `CEI_OFS_MODE)) begin
      rd_word[`CEI_MODE_LSB +: `CEI_MODE_W] = mode_q;                     // [RULE_07]
    end else if (hit(PADDR, `CEI_OFS_CTRL)) begin
      rd_word[`CEI_CTRL_WP_BIT] = protect_q;
    end else if (hit(PADDR, `CEI_OFS_EVT_STATUS)) begin
      rd_word[`CEI_N_EVT-1:0] = evt_status;
    end else if (hit(PADDR, `CEI_OFS_EVT_MASK)) begin
      rd_word[`CEI_N_EVT-1:0] = evt_mask_q;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (rd_snap) begin
        prdata_q <= rd_word;
      end
    end
  end

  // Software-held registers

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable_q <= `CEI_RST_FLAGS;
    end else if (wr_enable) begin
      enable_q <= src_field(PWDATA);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= cei_pkg::cei_mode_e'(`CEI_RST_MODE);
    end else if (wr_mode) begin
      mode_q <= cei_pkg::cei_mode_e'(PWDATA[`CEI_MODE_LSB +: `CEI_MODE_W]); // [RULE_08]
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      protect_q <= `CEI_RST_CTRL;
    end else if (wr_ctrl) begin
      protect_q <= PWDATA[`CEI_CTRL_WP_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      evt_mask_q <= `CEI_RST_EVT;
    end else if (wr_mask) begin
      evt_mask_q <= PWDATA[`CEI_N_EVT-1:0];
    end
  end

  // Force register

  assign force_wr      = wr_commit & hit(PADDR, `CEI_OFS_FORCE);
  assign force_ok      = force_wr & ~protect_q;                              // [RULE_06]
  assign force_refused = force_wr & protect_q & (|src_field(PWDATA));

  // Stored one cycle only; it is then applied and dropped
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      force_q <= `CEI_RST_FLAGS;
    end else if (force_ok) begin
      // Input side in hw bits 11:0, output side in 23:12; zeros force nothing
      force_q <= src_field(PWDATA);                                          // [RULE_02] [RULE_03] [RULE_04]
    end else begin
      force_q <= `CEI_RST_FLAGS;                                             // [RULE_05]
    end
  end

  // Notification flags

  always_comb begin
    hw_set = `CEI_RST_FLAGS;
    hw_set[`CEI_IN_LSB +: `CEI_N_SRC]  = INPUT_CMP_ERR;
    hw_set[`CEI_OUT_LSB +: `CEI_N_SRC] = OUTPUT_CMP_ERR;
  end

  // Forced bits merge with detections, so nothing downstream can tell them apart
  assign set_all = hw_set | force_q;                                         // [RULE_01] [RULE_03] [RULE_11]

  assign clr_w1  = wr_notify ? src_field(PWDATA) : `CEI_RST_FLAGS;

  assign new_flags = set_all & ~notify_q;

  always_comb begin
    // Set wins over a software clear in the same cycle; reads never clear
    notify_d = (notify_q & ~clr_w1) | set_all;                              // [RULE_09]
    // Pulse mode signals the event and keeps no record of it
    if (mode_q == cei_pkg::CEI_MODE_PULSE) begin                             // [RULE_08]
      notify_d = notify_d & ~enable_q;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      notify_q <= `CEI_RST_FLAGS;
    end else begin
      notify_q <= notify_d;
    end
  end

  // Checker interrupt line

  assign pending_en   = |(notify_q & enable_q);                              // [RULE_10]
  assign new_event_en = |(set_all & enable_q);                               // [RULE_10] [RULE_11]

  cei_line_gen u_line (
    .clk       (CLK),
    .rst_n     (RSTN),
    .mode      (mode_q),
    .pending   (pending_en),
    .new_event (new_event_en),
    .line_q    (line_q)
  );

  // Block events and the summary interrupt

  always_comb begin
    evt_set = `CEI_RST_EVT;
    evt_set[`CEI_EVT_FORCED]  = |force_q;
    evt_set[`CEI_EVT_REFUSED] = force_refused;
    evt_set[`CEI_EVT_ERROR]   = |new_flags;
  end

  // Clear with the snapshot: an event landing between snapshot and commit
  // would otherwise be wiped without ever having been read
  assign status_rd_clr = rd_snap & hit(PADDR, `CEI_OFS_EVT_STATUS);

  cei_evt_irq #(
    .N (`CEI_N_EVT)
  ) u_evt (
    .clk      (CLK),
    .rst_n    (RSTN),
    .evt_set  (evt_set),
    .rd_clr   (status_rd_clr),
    .mask     (evt_mask_q),
    .status_q (evt_status),
    .irq_q    (evt_irq)
  );

  // Outputs, all from flops

  assign PREADY                   = pready_q;
  assign PSLVERR                  = pslverr_q;
  assign PRDATA                   = prdata_q;
  assign ERROR_NOTIFICATION_FLAGS = notify_q;
  assign CHECKER_INTERRUPT_LINE   = line_q;
  assign IRQ                      = evt_irq;

endmodule

`default_nettype wire

// ### hdl/cei_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the compare-error interrupt block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Hardware bit n of a word is printed bit 31-n (printed numbering is big-endian)
`ifndef CEI_DEFS_SVH
`define CEI_DEFS_SVH

// Register byte offsets
`define CEI_OFS_NOTIFY     12'h000
`define CEI_OFS_ENABLE     12'h004
`define CEI_OFS_FORCE      12'h008
`define CEI_OFS_MODE       12'h00c
`define CEI_OFS_CTRL       12'h010
`define CEI_OFS_EVT_STATUS 12'h014
`define CEI_OFS_EVT_MASK   12'h018

// Field layout
`define CEI_N_SRC          12
`define CEI_N_FLAGS        24
`define CEI_IN_LSB         0
`define CEI_OUT_LSB        12
`define CEI_MODE_LSB       0
`define CEI_MODE_W         2
`define CEI_CTRL_WP_BIT    0
`define CEI_N_EVT          3
`define CEI_EVT_FORCED     0
`define CEI_EVT_REFUSED    1
`define CEI_EVT_ERROR      2

// Reset values
`define CEI_RST_FLAGS      24'h000000
`define CEI_RST_MODE       2'h0
`define CEI_RST_CTRL       1'h0
`define CEI_RST_EVT        3'h0

`endif

// ### hdl/cei_pkg.sv
// Purpose: Types shared by the compare-error interrupt block
// Assumes: Constants live in cei_defs.svh
// Notes:   Mode codes are the encodings software writes to the mode field
package cei_pkg;

  typedef enum logic [1:0] {
    CEI_MODE_LEVEL  = 2'h0,
    CEI_MODE_PULSE  = 2'h1,
    CEI_MODE_PNOTIF = 2'h2,
    CEI_MODE_SINGLE = 2'h3
  } cei_mode_e;

  typedef logic [23:0] cei_flags_t;

endpackage

// ### hdl/cei_line_gen.sv
// Purpose: Shapes the checker interrupt line according to the selected signalling mode
// Assumes: Inputs are already gated by the per-source enables
// Notes:   Pulses last one clock cycle
`timescale 1ns/1ps
`default_nettype none

module cei_line_gen (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire cei_pkg::cei_mode_e mode,
  // Enabled flag state
  input  wire logic              pending,
  input  wire logic              new_event,
  // Line
  output logic                   line_q
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= 1'b0;
    end else begin
      case (mode)
        cei_pkg::CEI_MODE_LEVEL:  line_q <= pending;
        cei_pkg::CEI_MODE_PULSE:  line_q <= new_event;
        cei_pkg::CEI_MODE_PNOTIF: line_q <= new_event;
        // Only the first event of a burst is signalled until the flags drain
        cei_pkg::CEI_MODE_SINGLE: line_q <= new_event & ~pending;
        default:                  line_q <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### hdl/cei_evt_irq.sv
// Purpose: Sticky event status with mask onto one level interrupt
// Assumes: Read of the status register clears it; set wins over the clear
// Notes:   irq_q follows the next status value so it rises with the status bit
`timescale 1ns/1ps
`default_nettype none

module cei_evt_irq #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Events and software
  input  wire logic [N-1:0] evt_set,
  input  wire logic         rd_clr,
  input  wire logic [N-1:0] mask,
  // State
  output logic [N-1:0]      status_q,
  output logic              irq_q
);

  logic [N-1:0] status_d;

  always_comb begin
    status_d = (rd_clr ? '0 : status_q) | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask);
    end
  end

endmodule

`default_nettype wire

// ### tb/cei_asserts.sv
// Purpose: Port-level assertions for the compare-error interrupt block
// Assumes: Shadows of enable, mode and protect track APB writes
// Notes:   Force checks need quiet detection inputs, or flags move anyway
`timescale 1ns/1ps
`include "cei_defs.svh"
`default_nettype none

module cei_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  // Detections and flags
  input wire logic [11:0] INPUT_CMP_ERR,
  input wire logic [11:0] OUTPUT_CMP_ERR,
  input wire logic [23:0] ERROR_NOTIFICATION_FLAGS,
  input wire logic        CHECKER_INTERRUPT_LINE
);
  logic        com;
  logic        rd;
  logic        fw;
  logic        quiet;
  logic [23:0] f;
  logic [23:0] wd;
  logic [23:0] en_q;
  logic [1:0]  mode_q;
  logic        wp_q;

  assign com   = PSEL && PENABLE && PREADY;
  assign rd    = com && !PWRITE;
  assign fw    = com && PWRITE && PADDR == `CEI_OFS_FORCE;
  assign quiet = (INPUT_CMP_ERR | OUTPUT_CMP_ERR) == 12'h000;
  assign f     = ERROR_NOTIFICATION_FLAGS;
  assign wd    = PWDATA[23:0];

  // Shadows spare the checker any probe into the bodies
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      en_q   <= 24'h000000;
      mode_q <= 2'h0;
      wp_q   <= 1'b0;
    end else if (com && PWRITE) begin
      if (PADDR == `CEI_OFS_ENABLE)
        en_q <= wd;
      if (PADDR == `CEI_OFS_MODE)
        mode_q <= PWDATA[1:0];
      if (PADDR == `CEI_OFS_CTRL)
        wp_q <= PWDATA[0];
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // Pulse mode drops enabled flags, so it is left out here
  sequence s_force;
    fw && !wp_q && mode_q != 2'h1 ##1 quiet;
  endsequence
  sequence s_refused;
    fw && wp_q ##1 quiet;
  endsequence

  property p_ready;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  property p_force_in;
    s_force |=> (f & $past(wd, 2) & 24'h000fff) == ($past(wd, 2) & 24'h000fff);
  endproperty
  property p_force_out;
    s_force |=> (f & $past(wd, 2) & 24'hfff000) == ($past(wd, 2) & 24'hfff000);
  endproperty
  property p_no_stray;
    s_force |=> (f & ~$past(f) & ~$past(wd, 2)) == 24'h000000;
  endproperty
  property p_protect;
    s_refused |=> (f & ~$past(f)) == 24'h000000;
  endproperty
  property p_force_zero;
    rd && PADDR == `CEI_OFS_FORCE |-> PRDATA == 32'h00000000;
  endproperty
  property p_mode_read;
    rd && PADDR == `CEI_OFS_MODE |-> PRDATA == {30'h0, mode_q};
  endproperty
  property p_clear;
    com && PWRITE && PADDR == `CEI_OFS_NOTIFY && quiet |=> (f & $past(wd)) == 24'h000000;
  endproperty
  property p_read_keeps;
    rd && PADDR == `CEI_OFS_NOTIFY && quiet && mode_q != 2'h1 |=> f == $past(f);
  endproperty
  property p_level;
    mode_q == 2'h0 |=> CHECKER_INTERRUPT_LINE == |($past(f) & $past(en_q));
  endproperty

  a_ready: assert property (p_ready) else $error("ready late");
  a_force_in: assert property (p_force_in) else $error("input flag not forced");
  a_force_out: assert property (p_force_out) else $error("output flag not forced");
  a_no_stray: assert property (p_no_stray) else $error("unforced flag set");
  a_protect: assert property (p_protect) else $error("protected force applied");
  a_force_zero: assert property (p_force_zero) else $error("force reads nonzero");
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
  a_clear: assert property (p_clear) else $error("flag not cleared");
  a_read_keeps: assert property (p_read_keeps) else $error("read changed flags");
  a_level: assert property (p_level) else $error("level line wrong");
endmodule

bind cei_top cei_asserts u_chk (
  .CLK(CLK),
  .RSTN(RSTN),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PREADY(PREADY),
  .PRDATA(PRDATA),
  .INPUT_CMP_ERR(INPUT_CMP_ERR),
  .OUTPUT_CMP_ERR(OUTPUT_CMP_ERR),
  .ERROR_NOTIFICATION_FLAGS(ERROR_NOTIFICATION_FLAGS),
  .CHECKER_INTERRUPT_LINE(CHECKER_INTERRUPT_LINE)
);

`default_nettype wire

// ### tb/cei_top_bench.sv
// Purpose: Directed APB test of force bits, modes, enables and events
// Assumes: One-wait-state APB slave; flags seen two edges after a force
// Notes:   Pulses are counted over a fixed window after the write
`timescale 1ns/1ps
`include "cei_defs.svh"
`default_nettype none

module cei_top_bench;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [11:0] in_err;
  logic [11:0] out_err;
  logic [23:0] flags;
  logic        line;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          check_count;
  int          cyc;
  int          n;
  int          k;

  cei_top DUT (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .INPUT_CMP_ERR(in_err),
    .OUTPUT_CMP_ERR(out_err), .ERROR_NOTIFICATION_FLAGS(flags), .CHECKER_INTERRUPT_LINE(line), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  // Leading edge keeps back-to-back calls from driving psel twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulses();
    k = 0;
    repeat (6) begin
      @(posedge clk);
      k += line;
    end
  endtask

  initial begin
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    in_err  = 12'h000;
    out_err = 12'h000;
    tick(10);
    rstn <= 1'b1;
    for (n = 0; n < 7; n++) begin
      apb(1'b0, 12'(n * 4), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (n = 0; n < 24; n++) begin
      apb(1'b1, `CEI_OFS_FORCE, 32'h1 << n);
      tick(2);
      chk(flags, 32'h1 << n);
      apb(1'b0, `CEI_OFS_FORCE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `CEI_OFS_NOTIFY, 32'h0);
      chk(rd, 32'h1 << n);
      apb(1'b1, `CEI_OFS_NOTIFY, 32'h1 << n);
      tick(1);
      chk(flags, 32'h0);
    end
    chk(irq, 1'b0);
    apb(1'b1, `CEI_OFS_EVT_MASK, 32'h2);
    apb(1'b0, `CEI_OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h5);
    // An all-zero force word, reserved byte included, must force nothing
    apb(1'b1, `CEI_OFS_FORCE, 32'h00000000);
    tick(2);
    chk(flags, 32'h0);
    apb(1'b0, `CEI_OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `CEI_OFS_CTRL, 32'h1);
    apb(1'b1, `CEI_OFS_FORCE, 32'h00ffffff);
    tick(2);
    chk(flags, 32'h0);
    chk(irq, 1'b1);
    apb(1'b0, `CEI_OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h2);
    tick(1);
    chk(irq, 1'b0);
    apb(1'b1, `CEI_OFS_CTRL, 32'h0);
    apb(1'b1, `CEI_OFS_ENABLE, 32'h00001001);
    apb(1'b0, `CEI_OFS_ENABLE, 32'h0);
    chk(rd, 32'h00001001);
    apb(1'b1, `CEI_OFS_FORCE, 32'h2);
    tick(3);
    chk(line, 1'b0);
    in_err  <= 12'h004;
    out_err <= 12'h001;
    @(posedge clk);
    in_err  <= 12'h000;
    out_err <= 12'h000;
    tick(2);
    chk(flags, 32'h1006);
    chk(line, 1'b1);
    apb(1'b1, `CEI_OFS_NOTIFY, 32'h1000);
    tick(2);
    chk(line, 1'b0);
    apb(1'b1, `CEI_OFS_FORCE, 32'h1);
    tick(3);
    chk(line, 1'b1);
    apb(1'b1, `CEI_OFS_NOTIFY, 32'h00ffffff);
    for (n = 1; n < 4; n++) begin
      apb(1'b1, `CEI_OFS_MODE, n);
      apb(1'b0, `CEI_OFS_MODE, 32'h0);
      chk(rd, n);
      apb(1'b1, `CEI_OFS_FORCE, 32'h1);
      pulses();
      chk(k, 1);
      chk(flags, n == 1 ? 0 : 1);
      apb(1'b1, `CEI_OFS_FORCE, 32'h1);
      pulses();
      chk(k, n == 3 ? 0 : 1);
      apb(1'b1, `CEI_OFS_NOTIFY, 32'h00ffffff);
    end
    stop_test();
  end
endmodule

`default_nettype wire
